// ### design/atc_regs.sv
/*
 * Register bank for auxiliary limits, identification words, scratch store and
 * calibration trims, with the calibration datapath behind it.
 * Assumes a byte-wide register port driven by the serial command decoder,
 * with multi-byte registers stored most significant byte at the lower address.
 */
// Notes on behaviour
// - Aux6 high limit in bits 15:2
// - Aux7 has separate low and high limits
// - Limits span 0 V to 5 V codes
// - Limit bits 1:0 read zero, written zero
// - Sixty-four scratch bits hold host data
// - Signed cell offset added to cell results
// - Cell offset step is one result LSB
// - Signed cell gain raises or lowers gain
// - Cell result times one plus gain/65536
// - Aux offset bits 9:0 signed, rest zero
// - Aux offset step is one result LSB
`timescale 1ns/10ps
module atc_regs #(
  parameter logic [63:0] LOT_ID = 64'h0123_4567_89ab_cdef, // Arbitrary value
  parameter logic [15:0] SERIAL_ID = 16'h5a5a // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic smp_valid,
  input wire logic smp_is_cell,
  input wire logic [2:0] smp_aux_idx,
  input wire logic [15:0] smp_raw,
  output logic res_valid,
  output logic res_is_cell,
  output logic [2:0] res_aux_idx,
  output logic [15:0] res_data,
  output logic aux6_high_fault,
  output logic aux7_low_fault,
  output logic aux7_high_fault
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [13:0] aux6_high_limit;
    logic [13:0] aux7_low_limit;
    logic [13:0] aux7_high_limit;
    logic [7:0] cell_offset_code;
    logic [7:0] cell_gain_code;
    logic [9:0] aux0_offset_code;
    logic [9:0] aux1_offset_code;
    logic [7:0] rdata;
    logic rd_valid;
    logic rd_from_mem;
  } atc_regs_s;

  atc_regs_s st_r;
  atc_regs_s st_nxt;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // One byte of a limit register; low byte carries bits 1:0 as zero
  function automatic logic [7:0] limit_byte(input logic [13:0] lim, input logic lo);
    limit_byte = lo ? {lim[5:0], 2'b00} : lim[13:6];
  endfunction : limit_byte

  // One byte of an aux offset register; bits 15:10 read zero
  function automatic logic [7:0] aux_ofs_byte(input logic [9:0] v, input logic lo);
    aux_ofs_byte = lo ? v[7:0] : {6'h00, v[9:8]};
  endfunction : aux_ofs_byte

  // New limit value after a byte write; written bits 1:0 are dropped
  function automatic logic [13:0] limit_wr(input logic [13:0] lim, input logic lo, input logic [7:0] d);
    limit_wr = lo ? {lim[13:6], d[7:2]} : {d, lim[5:0]};
  endfunction : limit_wr

  // New aux offset value after a byte write
  function automatic logic [9:0] aux_ofs_wr(input logic [9:0] v, input logic lo, input logic [7:0] d);
    aux_ofs_wr = lo ? {v[9:8], d} : {d[1:0], v[7:0]};
  endfunction : aux_ofs_wr

  // Address of the even byte that starts a word; both bytes of a word decode alike
  function automatic logic [7:0] word_base(input logic [7:0] a);
    word_base = {a[7:1], 1'b0};
  endfunction : word_base

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic lo_byte;
  logic [7:0] lot_ofs;
  logic [7:0] scr_ofs;
  logic in_lot;
  logic in_scr;
  logic [63:0] lot_shift;
  logic [7:0] mem_rdata;

  // Window hits for the multi-byte identification and scratch areas
  always_comb
  begin
    lo_byte = reg_addr[0];
    // Offsets below a base wrap to large values and miss the window
    lot_ofs = reg_addr - atc_pkg::ADDR_LOT;
    scr_ofs = reg_addr - atc_pkg::ADDR_SCRATCH;
    in_lot = (reg_addr >= atc_pkg::ADDR_LOT) && (lot_ofs < atc_pkg::LOT_BYTES);
    in_scr = (reg_addr >= atc_pkg::ADDR_SCRATCH) && (scr_ofs < atc_pkg::SCRATCH_BYTES);
    // Addressed lot byte moved into the top byte
    lot_shift = LOT_ID << {lot_ofs[2:0], 3'b000};
  end

  // ****************************************************************
  // Register writes and read capture
  // ****************************************************************

  // Next state of the bank; reads use the present state, so a byte read in
  // the cycle of its own write still answers with the old value
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rd_valid = reg_rd_en;
    // Host writes land one cycle later and steer calibration from then on
    if (reg_wr_en)
    begin
      unique case (word_base(reg_addr))
        // Limit bytes: the low byte drops written bits 1:0
        atc_pkg::ADDR_AUX6_HIGH:
        begin
          st_nxt.aux6_high_limit = limit_wr(st_r.aux6_high_limit, lo_byte, reg_wdata);
        end
        atc_pkg::ADDR_AUX7_LOW:
        begin
          st_nxt.aux7_low_limit = limit_wr(st_r.aux7_low_limit, lo_byte, reg_wdata);
        end
        atc_pkg::ADDR_AUX7_HIGH:
        begin
          st_nxt.aux7_high_limit = limit_wr(st_r.aux7_high_limit, lo_byte, reg_wdata);
        end
        // Single-byte trims share one word address
        atc_pkg::ADDR_CELL_OFS:
        begin
          if (lo_byte)
          begin
            st_nxt.cell_gain_code = reg_wdata;
          end
          else
          begin
            st_nxt.cell_offset_code = reg_wdata;
          end
        end
        // Aux offset bytes: the high byte keeps only bits 9:8
        atc_pkg::ADDR_AUX0_OFS:
        begin
          st_nxt.aux0_offset_code = aux_ofs_wr(st_r.aux0_offset_code, lo_byte, reg_wdata);
        end
        atc_pkg::ADDR_AUX1_OFS:
        begin
          st_nxt.aux1_offset_code = aux_ofs_wr(st_r.aux1_offset_code, lo_byte, reg_wdata);
        end
        default:
        begin
          // Identification words and unmapped addresses ignore writes
        end
      endcase
    end
    // A read picks its source; the source and the captured byte hold until the
    // next read, so reg_rdata stays put between reads
    if (reg_rd_en)
    begin
      st_nxt.rdata = atc_pkg::UNMAPPED_READ;
      st_nxt.rd_from_mem = 1'b0;
      // The multi-byte windows are decoded ahead of the word map
      if (in_lot)
      begin
        // Lot word goes out most significant byte first
        st_nxt.rdata = lot_shift[63:56];
      end
      else if (in_scr)
      begin
        // Scratch byte comes from the memory's own output register
        st_nxt.rd_from_mem = 1'b1;
      end
      else
      begin
        unique case (word_base(reg_addr))
          atc_pkg::ADDR_AUX6_HIGH:
          begin
            st_nxt.rdata = limit_byte(st_r.aux6_high_limit, lo_byte);
          end
          atc_pkg::ADDR_AUX7_LOW:
          begin
            st_nxt.rdata = limit_byte(st_r.aux7_low_limit, lo_byte);
          end
          atc_pkg::ADDR_AUX7_HIGH:
          begin
            st_nxt.rdata = limit_byte(st_r.aux7_high_limit, lo_byte);
          end
          // Serial word is fixed when the block is built
          atc_pkg::ADDR_SER:
          begin
            st_nxt.rdata = lo_byte ? SERIAL_ID[7:0] : SERIAL_ID[15:8];
          end
          // Gain at the odd address, offset at the even one
          atc_pkg::ADDR_CELL_OFS:
          begin
            st_nxt.rdata = lo_byte ? st_r.cell_gain_code : st_r.cell_offset_code;
          end
          atc_pkg::ADDR_AUX0_OFS:
          begin
            st_nxt.rdata = aux_ofs_byte(st_r.aux0_offset_code, lo_byte);
          end
          atc_pkg::ADDR_AUX1_OFS:
          begin
            st_nxt.rdata = aux_ofs_byte(st_r.aux1_offset_code, lo_byte);
          end
          default:
          begin
            st_nxt.rdata = atc_pkg::UNMAPPED_READ;
          end
        endcase
      end
    end
  end

  // State register with trims cleared and limits wide open at reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r.aux6_high_limit <= atc_pkg::LIMIT_OV_RST;
      st_r.aux7_low_limit <= atc_pkg::LIMIT_UV_RST;
      st_r.aux7_high_limit <= atc_pkg::LIMIT_OV_RST;
      st_r.cell_offset_code <= atc_pkg::TRIM_RST;
      st_r.cell_gain_code <= atc_pkg::TRIM_RST;
      st_r.aux0_offset_code <= atc_pkg::AUX_OFS_RST;
      st_r.aux1_offset_code <= atc_pkg::AUX_OFS_RST;
      st_r.rdata <= atc_pkg::UNMAPPED_READ;
      st_r.rd_valid <= 1'b0;
      st_r.rd_from_mem <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Scratch store and calibration datapath
  // ****************************************************************

  // Scratch bytes live in their own memory
  atc_scratch_mem #(
    .DEPTH(8),
    .WIDTH(8),
    .AW(3)
  ) u_scratch (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(reg_wr_en & in_scr),
    .wr_addr(scr_ofs[2:0]),
    .wr_data(reg_wdata),
    .rd_en(reg_rd_en & in_scr),
    .rd_addr(scr_ofs[2:0]),
    .rd_data(mem_rdata)
  );

  // Trims steer cell, aux0 and aux1 results; limits set the aux6 and aux7 fault levels
  atc_calib u_calib (
    .clk_sys(clk_sys),
    .rst(rst),
    .smp_valid(smp_valid),
    .smp_is_cell(smp_is_cell),
    .smp_aux_idx(smp_aux_idx),
    .smp_raw(smp_raw),
    .cell_offset_code(st_r.cell_offset_code),
    .cell_gain_code(st_r.cell_gain_code),
    .aux0_offset_code(st_r.aux0_offset_code),
    .aux1_offset_code(st_r.aux1_offset_code),
    .aux6_high_limit(st_r.aux6_high_limit),
    .aux7_low_limit(st_r.aux7_low_limit),
    .aux7_high_limit(st_r.aux7_high_limit),
    .res_valid(res_valid),
    .res_is_cell(res_is_cell),
    .res_aux_idx(res_aux_idx),
    .res_data(res_data),
    .aux6_high_fault(aux6_high_fault),
    .aux7_low_fault(aux7_low_fault),
    .aux7_high_fault(aux7_high_fault)
  );

  // Read answer picks between two flip-flop sources
  // so the scratch path needs no extra cycle of latency
  assign reg_rdata = st_r.rd_from_mem ? mem_rdata : st_r.rdata;
  assign reg_rd_valid = st_r.rd_valid;

endmodule : atc_regs

// ### design/atc_pkg.sv
/*
 * Shared constants of the auxiliary threshold and calibration register bank:
 * byte offsets, field positions, reset values and result widths.
 * Assumes a byte-wide register port in which each address holds one byte.
 */
package atc_pkg;

  // ****************************************************************
  // Byte offsets of the register map
  // ****************************************************************
  localparam logic [7:0] ADDR_AUX6_HIGH = 8'hac;
  localparam logic [7:0] ADDR_AUX7_LOW = 8'hae;
  localparam logic [7:0] ADDR_AUX7_HIGH = 8'hb0;
  localparam logic [7:0] ADDR_LOT = 8'hbe;
  localparam logic [7:0] ADDR_SER = 8'hc6;
  localparam logic [7:0] ADDR_SCRATCH = 8'hc8;
  localparam logic [7:0] ADDR_CELL_OFS = 8'hd2;
  localparam logic [7:0] ADDR_CELL_GAIN = 8'hd3;
  localparam logic [7:0] ADDR_AUX0_OFS = 8'hd4;
  localparam logic [7:0] ADDR_AUX1_OFS = 8'hd6;
  localparam logic [7:0] LOT_BYTES = 8'h08;
  localparam logic [7:0] SCRATCH_BYTES = 8'h08;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int LIMIT_LSB = 2;
  localparam int LIMIT_W = 14;
  localparam int TRIM_W = 8;
  localparam int AUX_OFS_W = 10;
  localparam int RESULT_W = 16;
  localparam int GAIN_SHIFT = 16;

  // ****************************************************************
  // Reset values and fixed read values
  // ****************************************************************
  localparam logic [13:0] LIMIT_OV_RST = 14'h3fff;
  localparam logic [13:0] LIMIT_UV_RST = 14'h0000;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [9:0] AUX_OFS_RST = 10'h000;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [15:0] RESULT_MAX = 16'hffff;

endpackage : atc_pkg

// ### design/atc_scratch_mem.sv
/*
 * Small byte memory that holds the host scratch store.
 * Assumes one write and one read port on the same clock; read data are registered.
 */
`timescale 1ns/10ps
module atc_scratch_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] q;
  } atc_mem_s;

  atc_mem_s st_r;
  atc_mem_s st_nxt;

  // Store written bytes, hand back old contents on a read
  always_comb
  begin
    st_nxt = st_r;
    if (wr_en)
    begin
      st_nxt.mem[wr_addr] = wr_data;
    end
    if (rd_en)
    begin
      st_nxt.q = st_r.mem[rd_addr];
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.q;

endmodule : atc_scratch_mem

// ### design/atc_calib.sv
/*
 * Calibration datapath: gain and offset trims on cell results, offset trims
 * on aux0 and aux1 results, then limit checks for the aux6 and aux7 auxiliary channels.
 * Assumes one sample at a time arriving with a one-cycle valid strobe.
 */
`timescale 1ns/10ps
module atc_calib (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic smp_valid,
  input wire logic smp_is_cell,
  input wire logic [2:0] smp_aux_idx,
  input wire logic [15:0] smp_raw,
  input wire logic [7:0] cell_offset_code,
  input wire logic [7:0] cell_gain_code,
  input wire logic [9:0] aux0_offset_code,
  input wire logic [9:0] aux1_offset_code,
  input wire logic [13:0] aux6_high_limit,
  input wire logic [13:0] aux7_low_limit,
  input wire logic [13:0] aux7_high_limit,
  output logic res_valid,
  output logic res_is_cell,
  output logic [2:0] res_aux_idx,
  output logic [15:0] res_data,
  output logic aux6_high_fault,
  output logic aux7_low_fault,
  output logic aux7_high_fault
);

  typedef struct packed {
    logic valid;
    logic is_cell;
    logic [2:0] aux_idx;
    logic [15:0] data;
    logic aux6_hi;
    logic aux7_lo;
    logic aux7_hi;
  } atc_cal_s;

  atc_cal_s st_r;
  atc_cal_s st_nxt;

  // Clamp a signed sum into the unsigned result range
  function automatic logic [15:0] clamp_result(input logic signed [19:0] v);
    if (v < 20'sd0)
    begin
      clamp_result = 16'h0000;
    end
    else if (v > $signed({4'h0, atc_pkg::RESULT_MAX}))
    begin
      clamp_result = atc_pkg::RESULT_MAX;
    end
    else
    begin
      clamp_result = v[15:0];
    end
  endfunction : clamp_result

  // Limit field scaled up to a full result code, low bits zero
  function automatic logic [15:0] limit_code(input logic [13:0] lim);
    limit_code = {lim, 2'b00};
  endfunction : limit_code

  logic signed [24:0] gain_prod;
  logic signed [19:0] gain_adj;
  logic signed [19:0] ofs_adj;
  logic signed [19:0] cal_sum;
  logic [15:0] cal;

  // Trim arithmetic ahead of storage and comparison
  always_comb
  begin
    gain_prod = $signed({1'b0, smp_raw}) * $signed(cell_gain_code);
    gain_adj = smp_is_cell ? 20'(gain_prod >>> atc_pkg::GAIN_SHIFT) : 20'sd0;
    if (smp_is_cell)
    begin
      ofs_adj = 20'($signed(cell_offset_code));
    end
    else if (smp_aux_idx == 3'h0)
    begin
      ofs_adj = 20'($signed(aux0_offset_code));
    end
    else if (smp_aux_idx == 3'h1)
    begin
      ofs_adj = 20'($signed(aux1_offset_code));
    end
    else
    begin
      ofs_adj = 20'sd0;
    end
    cal_sum = $signed({4'h0, smp_raw}) + gain_adj + ofs_adj;
    cal = clamp_result(cal_sum);
  end

  // Result register and fault levels, refreshed by each matching sample
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.valid = smp_valid;
    if (smp_valid)
    begin
      st_nxt.is_cell = smp_is_cell;
      st_nxt.aux_idx = smp_aux_idx;
      st_nxt.data = cal;
      if (!smp_is_cell && smp_aux_idx == 3'h6)
      begin
        st_nxt.aux6_hi = cal > limit_code(aux6_high_limit);
      end
      if (!smp_is_cell && smp_aux_idx == 3'h7)
      begin
        st_nxt.aux7_lo = cal < limit_code(aux7_low_limit);
        st_nxt.aux7_hi = cal > limit_code(aux7_high_limit);
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign res_valid = st_r.valid;
  assign res_is_cell = st_r.is_cell;
  assign res_aux_idx = st_r.aux_idx;
  assign res_data = st_r.data;
  assign aux6_high_fault = st_r.aux6_hi;
  assign aux7_low_fault = st_r.aux7_lo;
  assign aux7_high_fault = st_r.aux7_hi;

endmodule : atc_calib

// ### tb/atc_regs_sva.sv
/*
 * Checker for the register bank ports: read answers, sample answers,
 * fixed-zero bits and fault holding.
 * Assumes one clock domain and an active-high reset; bound onto atc_regs.
 */
`timescale 1ns/10ps
module atc_regs_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic smp_valid,
  input wire logic smp_is_cell,
  input wire logic [2:0] smp_aux_idx,
  input wire logic [15:0] smp_raw,
  input wire logic res_valid,
  input wire logic res_is_cell,
  input wire logic [15:0] res_data,
  input wire logic aux6_high_fault
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ****************************************************************
  // Request sequences
  // ****************************************************************
  sequence s_rd_limit_lo;
    reg_rd_en && (reg_addr inside {8'had, 8'haf, 8'hb1});
  endsequence
  sequence s_rd_ofs_hi;
    reg_rd_en && (reg_addr inside {8'hd4, 8'hd6});
  endsequence
  sequence s_aux_plain;
    smp_valid && !smp_is_cell && (smp_aux_idx > 3'h1);
  endsequence

  // ****************************************************************
  // Assertions
  // ****************************************************************
  read_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read strobe not answered next cycle");
  read_pulse_a: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("read valid without a read strobe");
  limit_low_bits_a: assert property (s_rd_limit_lo |=> reg_rdata[1:0] == 2'h0)
    else $error("limit bits 1:0 read nonzero");
  ofs_high_bits_a: assert property (s_rd_ofs_hi |=> reg_rdata[7:2] == 6'h00)
    else $error("aux offset reserved bits read nonzero");
  sample_answer_a: assert property (smp_valid |=> res_valid)
    else $error("sample not answered next cycle");
  sample_pulse_a: assert property (!smp_valid |=> !res_valid)
    else $error("result valid without a sample");
  sample_tag_a: assert property (smp_valid |=> res_is_cell == $past(smp_is_cell))
    else $error("result channel kind differs from sample");
  aux_plain_a: assert property (s_aux_plain |=> res_data == $past(smp_raw))
    else $error("untrimmed aux channel result altered");
  aux6_hold_a: assert property (!(smp_valid && !smp_is_cell && smp_aux_idx == 3'h6)
    |=> $stable(aux6_high_fault))
    else $error("aux6 fault changed without an aux6 sample");
endmodule : atc_regs_sva

bind atc_regs atc_regs_sva u_sva (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
  .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .smp_valid(smp_valid), .smp_is_cell(smp_is_cell),
  .smp_aux_idx(smp_aux_idx), .smp_raw(smp_raw), .res_valid(res_valid), .res_is_cell(res_is_cell),
  .res_data(res_data), .aux6_high_fault(aux6_high_fault));

// ### tb/atc_host_model.sv
/*
 * Host model: byte writes and reads over the register command port.
 * Assumes the testbench calls its tasks one at a time.
 */
`timescale 1ns/10ps
module atc_host_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid
);
  // Idle port at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end

  // One strobe per byte; limit low bytes leave with bits 1:0 cleared
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= (a inside {8'had, 8'haf, 8'hb1}) ? (d & 8'hfc) : d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // One-cycle read strobe; flag and byte are taken at the edge where they are sampled
  task automatic rd(input logic [7:0] a, output logic [8:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    @(posedge clk_sys);
    q = {reg_rd_valid, reg_rdata};
  endtask : rd
endmodule : atc_host_model

// ### tb/atc_regs_tb.sv
/*
 * Testbench for the register bank: reset values, identity words, scratch,
 * limits with faults and calibration trims.
 * Assumes the host model drives the register port.
 */
`timescale 1ns/10ps
module atc_regs_tb;
  localparam logic [63:0] LOT = 64'h1122_3344_5566_7788; // Arbitrary value
  localparam logic [15:0] SER = 16'hc3a5; // Arbitrary value
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr_en, reg_rd_en, reg_rd_valid;
  logic smp_valid = 1'b0;
  logic smp_is_cell = 1'b0;
  logic [2:0] smp_aux_idx = 3'h0;
  logic [15:0] smp_raw = 16'h0000;
  logic res_valid, res_is_cell, aux6_high_fault, aux7_low_fault, aux7_high_fault;
  logic [2:0] res_aux_idx;
  logic [15:0] res_data;
  int n_errors = 0;
  int samples_checked = 0;

  // Clock
  always #5 clk_sys = ~clk_sys;

  atc_regs #(.LOT_ID(LOT), .SERIAL_ID(SER)) u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .smp_valid(smp_valid), .smp_is_cell(smp_is_cell), .smp_aux_idx(smp_aux_idx),
    .smp_raw(smp_raw), .res_valid(res_valid), .res_is_cell(res_is_cell), .res_aux_idx(res_aux_idx),
    .res_data(res_data), .aux6_high_fault(aux6_high_fault), .aux7_low_fault(aux7_low_fault),
    .aux7_high_fault(aux7_high_fault));
  atc_host_model u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

  // ****************************************************************
  // Shared checks
  // ****************************************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Reads one byte and expects an answer with the given value
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [8:0] q;
    u_host.rd(a, q);
    chk("reg_rdata", {7'h00, 1'b1, e}, {7'h00, q});
  endtask : rc

  // Sends one sample and checks the calibrated result and fault levels
  task automatic smp(input logic c, input logic [2:0] ix, input logic [15:0] raw, input logic [15:0] e,
    input logic [2:0] f);
    @(posedge clk_sys);
    smp_valid <= 1'b1;
    smp_is_cell <= c;
    smp_aux_idx <= ix;
    smp_raw <= raw;
    @(posedge clk_sys);
    smp_valid <= 1'b0;
    smp_raw <= ~raw;
    @(posedge clk_sys);
    chk("res_data", e, res_valid ? res_data : ~e);
    chk("res_tag", {12'h000, c, ix}, {12'h000, res_is_cell, res_aux_idx});
    chk("faults", {13'h0000, f}, {13'h0000, aux6_high_fault, aux7_low_fault, aux7_high_fault});
  endtask : smp

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [7:0] a[12] = '{8'hac, 8'had, 8'hae, 8'haf, 8'hb0, 8'hb1, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hc8, 8'hd0};
    logic [7:0] e[12] = '{8'hff, 8'hfc, 8'h00, 8'h00, 8'hff, 8'hfc, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 12; i++)
      rc(a[i], e[i]);
  endtask : t_reset

  task automatic t_ident();
    u_host.wr(8'hbe, 8'h00);
    u_host.wr(8'hc6, 8'h00);
    for (int i = 0; i < 8; i++)
      rc(8'hbe + 8'(i), LOT[63 - 8 * i -: 8]);
    rc(8'hc6, SER[15:8]);
    rc(8'hc7, SER[7:0]);
  endtask : t_ident

  task automatic t_scratch();
    for (int i = 0; i < 8; i++)
      u_host.wr(8'hc8 + 8'(i), 8'h81 + 8'(17 * i));
    for (int i = 0; i < 8; i++)
      rc(8'hc8 + 8'(i), 8'h81 + 8'(17 * i));
    @(posedge clk_sys);
    chk("reg_rdata_hold", {8'h00, 8'h81 + 8'(17 * 7)}, {8'h00, reg_rdata});
  endtask : t_scratch

  task automatic t_limits();
    u_host.wr(8'hac, 8'h20);
    u_host.wr(8'had, 8'h00);
    u_host.wr(8'hae, 8'h10);
    u_host.wr(8'haf, 8'h00);
    u_host.wr(8'hb0, 8'h30);
    u_host.wr(8'hb1, 8'h07);
    rc(8'hb1, 8'h04);
    smp(1'b0, 3'h6, 16'h2000, 16'h2000, 3'b000);
    smp(1'b0, 3'h6, 16'h2001, 16'h2001, 3'b100);
    smp(1'b0, 3'h7, 16'h0fff, 16'h0fff, 3'b110);
    smp(1'b0, 3'h7, 16'h1000, 16'h1000, 3'b100);
    smp(1'b0, 3'h7, 16'h3005, 16'h3005, 3'b101);
    smp(1'b0, 3'h7, 16'h3004, 16'h3004, 3'b100);
    u_host.wr(8'hac, 8'hff);
    u_host.wr(8'had, 8'hff);
    smp(1'b0, 3'h6, 16'hfffc, 16'hfffc, 3'b000);
    smp(1'b0, 3'h6, 16'hffff, 16'hffff, 3'b100);
  endtask : t_limits

  task automatic t_cell();
    u_host.wr(8'hd2, 8'hfe);
    smp(1'b1, 3'h0, 16'h1000, 16'h0ffe, 3'b100);
    smp(1'b0, 3'h3, 16'h1234, 16'h1234, 3'b100);
    u_host.wr(8'hd2, 8'h7f);
    smp(1'b1, 3'h0, 16'hffff, 16'hffff, 3'b100);
    u_host.wr(8'hd2, 8'h00);
    u_host.wr(8'hd3, 8'h7f);
    smp(1'b1, 3'h0, 16'h8000, 16'h803f, 3'b100);
    u_host.wr(8'hd3, 8'h80);
    smp(1'b1, 3'h0, 16'h8000, 16'h7fc0, 3'b100);
    rc(8'hd3, 8'h80);
  endtask : t_cell

  task automatic t_aux();
    u_host.wr(8'hd4, 8'hff);
    u_host.wr(8'hd5, 8'hff);
    rc(8'hd4, 8'h03);
    smp(1'b0, 3'h0, 16'h0010, 16'h000f, 3'b100);
    u_host.wr(8'hd6, 8'h01);
    u_host.wr(8'hd7, 8'hff);
    smp(1'b0, 3'h1, 16'h1000, 16'h11ff, 3'b100);
    u_host.wr(8'hd4, 8'h02);
    u_host.wr(8'hd5, 8'h00);
    smp(1'b0, 3'h0, 16'h0100, 16'h0000, 3'b100);
  endtask : t_aux

  // Prints the counts and the verdict, then stops
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_ident();
    t_scratch();
    t_limits();
    t_cell();
    t_aux();
    complete_run();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #100us;
    n_errors++;
    complete_run();
  end
endmodule : atc_regs_tb
